// *** dv/synth_host_model.sv ***
// Host controller model driving programming writes and the mute pin
`timescale 1ns/1ps
module synth_host_model (
  input wire logic core_clk_i,
  output logic wr_en_o,
  output logic [2:0] wr_sel_o,
  output logic [31:0] wr_data_o,
  output logic cw0_wr_o,
  output logic cal_trigger_o,
  output logic silence_pin_o
);
  // Idle levels at time zero
  initial
  begin
    wr_en_o = 1'b0;
    wr_sel_o = 3'h0;
    wr_data_o = 32'h0;
    cw0_wr_o = 1'b0;
    cal_trigger_o = 1'b0;
    silence_pin_o = 1'b0;
  end
  // One-edge write; data inverted after so a stale value never matches
  task automatic wr(input logic [2:0] s, input logic [31:0] d);
    @(posedge core_clk_i);
    wr_en_o <= 1'b1;
    wr_sel_o <= s;
    wr_data_o <= d;
    @(posedge core_clk_i);
    wr_en_o <= 1'b0;
    wr_data_o <= ~d;
  endtask
  task automatic cw0(input logic t);
    @(posedge core_clk_i);
    cw0_wr_o <= 1'b1;
    cal_trigger_o <= t;
    @(posedge core_clk_i);
    cw0_wr_o <= 1'b0;
    cal_trigger_o <= ~t;
  endtask
  // Mute pin level change
  task automatic mute(input logic v);
    @(posedge core_clk_i);
    silence_pin_o <= v;
  endtask
endmodule

// *** dv/synth_shadow_cal_control_bench.sv ***
// Bench comparing the control block with a behavioural model
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_count++; \
  $display("[FAIL] t=%0t got=%0h exp=%0h", $time, a, b); end end
module synth_shadow_cal_control_bench;
  localparam int FULL_N = 20;
  localparam int FAST_N = 250;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic shadow_en = 1'b0, mute_pol = 1'b0, ext_osc = 1'b0, fast_en = 1'b0;
  logic [1:0] fb_mode = 2'h0, single_sel = 2'h0;
  logic wr_en, cw0_wr, cal_trig, silence;
  logic [2:0] wr_sel;
  logic [31:0] wr_data;
  logic [31:0] act_w [8];
  logic rf_en, sysref, aux_ok, fb_ok, fc_valid, busy, done;
  logic [31:0] act_m [8], held_m [8];
  logic [4:0] modes [4] = '{5'h10, 5'h04, 5'h07, 5'h08};
  int err_count = 0, n_compared = 0, cyc = 0, n;
  synth_host_model host (.core_clk_i(core_clk_i), .wr_en_o(wr_en), .wr_sel_o(wr_sel),
    .wr_data_o(wr_data), .cw0_wr_o(cw0_wr), .cal_trigger_o(cal_trig), .silence_pin_o(silence));
  synth_shadow_cal_control #(.FULLCAL_CYCLES(FULL_N)) uut (.core_clk_i(core_clk_i),
    .rst_i(rst_i), .wr_en_i(wr_en), .wr_sel_i(wr_sel), .wr_data_i(wr_data),
    .cw0_wr_i(cw0_wr), .cal_trigger_i(cal_trig), .shadow_enable_i(shadow_en),
    .mute_polarity_i(mute_pol), .silence_pin_i(silence), .ext_osc_mode_i(ext_osc),
    .fb_mode_i(fb_mode), .single_detector_sel_i(single_sel), .fastcal_enable_i(fast_en),
    .active_word0_o(act_w[0]), .active_word1_o(act_w[1]), .active_word2_o(act_w[2]),
    .active_word3_o(act_w[3]), .active_word4_o(act_w[4]), .active_word5_o(act_w[5]),
    .active_word6_o(act_w[6]), .active_word7_o(act_w[7]), .rf_out_enable_o(rf_en),
    .sysref_avail_o(sysref), .aux_div_one_ok_o(aux_ok), .fb_path_ok_o(fb_ok),
    .fastcal_valid_o(fc_valid), .cal_busy_o(busy), .cal_done_o(done));
  // 100 MHz clock
  initial
  begin
    forever #5 core_clk_i = ~core_clk_i;
  end
  // Hang guard, well above the roughly 620 cycles of the run
  always @(posedge core_clk_i)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_count++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    if (err_count == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Words and mode outputs against the model, after the edge settles
  task automatic chk();
    #1;
    for (int i = 0; i < 8; i++)
    begin
      `CHK(act_w[i], act_m[i])
    end
    `CHK(rf_en, !ext_osc && (silence != mute_pol))
    `CHK(sysref, 1'b1)
    `CHK(aux_ok, fb_mode == 2'h1)
    `CHK(fb_ok, !(fb_mode == 2'h1 && single_sel != 2'h3))
  endtask
  task automatic setm(input logic sh, mp, sp, eo, input logic [1:0] fm, ss);
    host.mute(sp);
    shadow_en <= sh;
    mute_pol <= mp;
    ext_osc <= eo;
    fb_mode <= fm;
    single_sel <= ss;
    repeat (2) @(posedge core_clk_i);
    chk();
  endtask
  // Held copy always tracks; active copy only while shadowing is off
  task automatic wr(input logic [2:0] s, input logic [31:0] d);
    host.wr(s, d);
    held_m[s] = d;
    if (!shadow_en) act_m[s] = d;
    chk();
  endtask
  task automatic commit(input logic t);
    host.cw0(t);
    if (shadow_en) act_m = held_m;
    chk();
  endtask
  // Busy cycles counted up to the done pulse
  task automatic calrun(input logic t, input int exp_n);
    commit(t);
    n = 0;
    while (done !== 1'b1 && n < 2000)
    begin
      n += int'(busy === 1'b1);
      @(posedge core_clk_i);
      #1;
    end
    `CHK(n, exp_n)
  endtask
  initial
  begin
    void'($urandom(79));
    foreach (act_m[i])
    begin
      act_m[i] = 32'h0;
      held_m[i] = 32'h0;
    end
    repeat (12) @(posedge core_clk_i);
    rst_i <= 1'b0;
    for (int k = 0; k < 4; k++) setm(1'b0, k[1], k[0], 1'b0, 2'h0, 2'h0);
    for (int k = 0; k < 4; k++) setm(1'b0, 1'b0, 1'b1, modes[k][4], modes[k][3:2], modes[k][1:0]);
    // halver left zero, oscillator kept below 11.3 GHz
    setm(1'b0, 1'b0, 1'b1, 1'b1, 2'h0, 2'h0);
    // order three, lowest band gives code four
    wr(3'h6, 32'h0000_0003);
    wr(3'h7, 32'h0000_0004);
    for (int i = 7; i >= 0; i--) wr(3'(i), $urandom);
    // Shadowed writes while muted, then one commit
    setm(1'b1, 1'b0, 1'b0, 1'b0, 2'h0, 2'h0);
    for (int i = 7; i >= 0; i--) wr(3'(i), $urandom);
    commit(1'b0);
    setm(1'b0, 1'b0, 1'b1, 1'b0, 2'h0, 2'h0);
    // timeout word held outside this block
    @(posedge core_clk_i);
    fast_en <= 1'b1;
    calrun(1'b1, FULL_N);
    @(posedge core_clk_i);
    #1;
    `CHK(fc_valid, 1'b1)
    for (int i = 2; i >= 0; i--) wr(3'(i), $urandom);
    calrun(1'b0, FAST_N);
    calrun(1'b1, FAST_N);
    @(posedge core_clk_i);
    fast_en <= 1'b0;
    @(posedge core_clk_i);
    fast_en <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    #1;
    `CHK(fc_valid, 1'b0)
    give_verdict();
  end
endmodule

// *** hdl/synth_shadow_cal_control.sv ***
// Shadow buffering, mute, mode and fast-calibration control for the synthesizer
`timescale 1ns/1ps
`include "synth_cfg_params.svh"
module synth_shadow_cal_control #(
  parameter int FULLCAL_CYCLES = `FULLCAL_CYCLES_DEF
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic wr_en_i,
  input wire logic [2:0] wr_sel_i,
  input wire logic [31:0] wr_data_i,
  input wire logic cw0_wr_i,
  input wire logic cal_trigger_i,
  input wire logic shadow_enable_i,
  input wire logic mute_polarity_i,
  input wire logic silence_pin_i,
  input wire logic ext_osc_mode_i,
  input wire logic [1:0] fb_mode_i,
  input wire logic [1:0] single_detector_sel_i,
  input wire logic fastcal_enable_i,
  output logic [31:0] active_word0_o,
  output logic [31:0] active_word1_o,
  output logic [31:0] active_word2_o,
  output logic [31:0] active_word3_o,
  output logic [31:0] active_word4_o,
  output logic [31:0] active_word5_o,
  output logic [31:0] active_word6_o,
  output logic [31:0] active_word7_o,
  output logic rf_out_enable_o,
  output logic sysref_avail_o,
  output logic aux_div_one_ok_o,
  output logic fb_path_ok_o,
  output logic fastcal_valid_o,
  output logic cal_busy_o,
  output logic cal_done_o
);
  // ----------------------------------------------------------------
  // Shadow and active words
  // ----------------------------------------------------------------
  // Index 0..7: feedback_int, frac_numerator, frac_denominator, ref_scaler,
  // ref_divider, ref_prediv, modulator_order, detector_delay
  logic [31:0] held [`SHADOW_COUNT];
  logic [31:0] active [`SHADOW_COUNT];
  logic fast_armed;
  logic fast_stored;
  logic fast_en_d;
  logic [15:0] cal_cnt;
  logic [15:0] busy_run;
  synth_cfg_pkg::cal_state_e cal_state;

  // Held copy always tracks writes so a later commit sees the newest value
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < `SHADOW_COUNT; i++)
        held[i] <= 32'h0000_0000;
    end
    else if (wr_en_i)
      held[wr_sel_i] <= wr_data_i;
  end

  // Active copy: direct when unshadowed, bulk commit on control word zero
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < `SHADOW_COUNT; i++)
        active[i] <= 32'h0000_0000;
    end
    else
    begin
      // R19: immediate apply path
      if (wr_en_i && !shadow_enable_i)
        active[wr_sel_i] <= wr_data_i;
      // R1: commit all held words
      // R2: covers the whole buffered set
      if (cw0_wr_i && shadow_enable_i)
      begin
        for (int i = 0; i < `SHADOW_COUNT; i++)
          active[i] <= held[i];
        if (wr_en_i)
          active[wr_sel_i] <= wr_data_i;
      end
    end
  end

  assign active_word0_o = active[0];
  assign active_word1_o = active[1];
  assign active_word2_o = active[2];
  assign active_word3_o = active[3];
  assign active_word4_o = active[4];
  assign active_word5_o = active[5];
  assign active_word6_o = active[6];
  assign active_word7_o = active[7];

  // ----------------------------------------------------------------
  // Mute and mode decode
  // ----------------------------------------------------------------
  // R3: polarity-selected mute; R4: writes keep flowing regardless
  // R5: external oscillator removes RF buffers only
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rf_out_enable_o <= 1'b0;
      sysref_avail_o <= 1'b0;
    end
    else
    begin
      rf_out_enable_o <= !ext_osc_mode_i && (silence_pin_i == mute_polarity_i ? 1'b0 : 1'b1);
      sysref_avail_o <= 1'b1;
    end
  end

  // R10: divide-by-one allowed on auxiliary path
  // R11: RF-input path needs no single-detector select
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      aux_div_one_ok_o <= 1'b0;
      fb_path_ok_o <= 1'b1;
    end
    else
    begin
      aux_div_one_ok_o <= (fb_mode_i == 2'(synth_cfg_pkg::FB_AUX_DETECTOR));
      if (fb_mode_i == 2'(synth_cfg_pkg::FB_AUX_DETECTOR))
        fb_path_ok_o <= (single_detector_sel_i == `SINGLE_DET_ON);
      else
        fb_path_ok_o <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Fast calibration
  // ----------------------------------------------------------------
  // R13: rising enable clears stored settings and arms generation
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      fast_en_d <= 1'b0;
      fast_armed <= 1'b0;
      fast_stored <= 1'b0;
    end
    else
    begin
      fast_en_d <= fastcal_enable_i;
      if (fastcal_enable_i && !fast_en_d)
      begin
        fast_armed <= 1'b1;
        fast_stored <= 1'b0;
      end
      else if (cal_state == synth_cfg_pkg::CAL_FULL && cal_cnt == 16'h0001 && fast_armed)
      begin
        fast_armed <= 1'b0;
        fast_stored <= 1'b1;
      end
      else if (!fastcal_enable_i)
        fast_armed <= 1'b0;
    end
  end
  assign fastcal_valid_o = fast_stored && fastcal_enable_i;

  // R17: fast path reuses stored settings in fixed time
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cal_state <= synth_cfg_pkg::CAL_IDLE;
      cal_cnt <= 16'h0000;
      cal_done_o <= 1'b0;
    end
    else
    begin
      cal_done_o <= 1'b0;
      case (cal_state)
        synth_cfg_pkg::CAL_IDLE:
        begin
          if (cw0_wr_i && fastcal_valid_o)
          begin
            cal_state <= synth_cfg_pkg::CAL_FAST;
            cal_cnt <= 16'(`FASTCAL_CYCLES);
          end
          else if (cw0_wr_i && cal_trigger_i)
          begin
            cal_state <= synth_cfg_pkg::CAL_FULL;
            cal_cnt <= 16'(FULLCAL_CYCLES);
          end
        end
        synth_cfg_pkg::CAL_FULL, synth_cfg_pkg::CAL_FAST:
        begin
          cal_cnt <= cal_cnt - 16'h0001;
          if (cal_cnt == 16'h0001)
          begin
            cal_state <= synth_cfg_pkg::CAL_IDLE;
            cal_done_o <= 1'b1;
          end
        end
        default:
          cal_state <= synth_cfg_pkg::CAL_IDLE;
      endcase
    end
  end
  assign cal_busy_o = (cal_state != synth_cfg_pkg::CAL_IDLE);

  // Length of the current busy run; lets the timing check avoid a long repetition
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      busy_run <= 16'h0000;
    else if (cal_busy_o)
      busy_run <= busy_run + 16'h0001;
    else
      busy_run <= 16'h0000;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  AST_SHADOW_HOLD: assert property ( // R1
    wr_en_i && shadow_enable_i && !cw0_wr_i |=> active[$past(wr_sel_i)] == $past(active[wr_sel_i]))
    else $error("Shadowed write applied early");
  AST_COMMIT: assert property ( // R2
    cw0_wr_i && shadow_enable_i && !wr_en_i |=> active[7] == $past(held[7]) && active[0] == $past(held[0]))
    else $error("Commit missed a held word");
  AST_DIRECT: assert property ( // R19
    wr_en_i && !shadow_enable_i |=> active[$past(wr_sel_i)] == $past(wr_data_i))
    else $error("Direct write not applied");
  AST_MUTE: assert property ( // R3
    silence_pin_i == mute_polarity_i |=> !rf_out_enable_o)
    else $error("Output not muted");
  AST_UNMUTE: assert property ( // R3
    silence_pin_i != mute_polarity_i && !ext_osc_mode_i |=> rf_out_enable_o)
    else $error("Output not unmuted");
  AST_EXTOSC: assert property ( // R5
    ext_osc_mode_i |=> !rf_out_enable_o && sysref_avail_o)
    else $error("External oscillator mode outputs wrong");
  AST_FEEDBACK_RF_INPUT: assert property ( // R11
    fb_mode_i == 2'h2 |=> fb_path_ok_o)
    else $error("RF feedback blocked");
  AST_AUXDIV: assert property ( // R10
    fb_mode_i == 2'h1 |=> aux_div_one_ok_o)
    else $error("Aux divider one refused");
  AST_ARM: assert property ( // R13
    $rose(fastcal_enable_i) |=> fast_armed && !fast_stored)
    else $error("Fast calibration not armed");
  AST_FASTTIME: assert property ( // R17
    cal_state == synth_cfg_pkg::CAL_IDLE && cw0_wr_i && fastcal_valid_o
      |=> ##249 (cal_busy_o && busy_run == 16'h00F9) ##1 (cal_done_o && !cal_busy_o))
    else $error("Fast calibration time wrong");
  COV_COMMIT: cover property (cw0_wr_i && shadow_enable_i);
  COV_FAST: cover property (cal_state == synth_cfg_pkg::CAL_FAST);
  COV_MUTE: cover property (!rf_out_enable_o && wr_en_i);
endmodule

// *** inc/synth_cfg_params.svh ***
// Constants for the synthesizer shadow, mute, mode and fast-calibration control block
// What this block and its host do
// R1: With shadowing on, buffered writes are held, then all applied on control word zero.
// R2: Shadowed set: feedback_int, numerator, denominator, scalers, dividers, order, delay.
// R3: Output mute follows silence_pin, active level chosen by mute_polarity.
// R4: Muted output keeps lock and still accepts writes and retunes.
// R5: External oscillator mode disables RF output buffers; SYSREF stays usable.
// R6: Host sets ext_osc_halver for external oscillator above 11.3 GHz, else zero.
// R7: Host sets detector_delay_override and loads detector_delay for external oscillator.
// R8: Host picks detector_delay by feedback band and modulator order from the table.
// R9: Host sets single_detector_sel to 3 for auxiliary detector feedback.
// R10: Auxiliary feedback divider accepts divide values down to one.
// R11: RF-input feedback works without single-detector operation.
// R12: Host loads fastcal_timeout from delay, reference MHz and calibration clock divider.
// R13: Rising fastcal_enable clears stored settings and arms generation on next trigger.
// R14: Host sets fastcal_doubler_flag when the output doubler is used.
// R15: Host setup: 5.65 GHz, fraction, trigger write, plain write, wait for lock.
// R16: Host retune: load fraction and divider words, write control word zero.
// R17: Initialized fast calibration completes in 2.5 us reusing stored settings.
// R18: Host writes registers in descending order, control word zero last.
// R19: Unbuffered registers, and all when shadowing is off, apply immediately.
`ifndef SYNTH_CFG_PARAMS_SVH
`define SYNTH_CFG_PARAMS_SVH
`define CLK_PERIOD_NS 10
`define FASTCAL_TIME_NS 2500
`define FASTCAL_CYCLES ((`FASTCAL_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FULLCAL_CYCLES_DEF 4096
`define SINGLE_DET_ON 2'h3
`define SHADOW_COUNT 8
`endif

// *** inc/synth_cfg_pkg.sv ***
// Types for the synthesizer configuration control block
package synth_cfg_pkg;
  typedef enum logic [1:0] {CAL_IDLE, CAL_FULL, CAL_FAST} cal_state_e;
  typedef enum logic [1:0] {FB_INTERNAL, FB_AUX_DETECTOR, FB_RF_INPUT} fb_mode_e;
endpackage
